// [logic/codec_page0_regs.v]
// Page-0 control register bank with supply, sleep and reference control
//
// Our own choice: the strobed register port.
`include "codec_page0_defs.vh"
`default_nettype none
module codec_page0_regs
#(
  parameter CNT_W = `CNT_W,
  parameter [CNT_W-1:0] QCHG_CYC0 =
    `QCHG_T0_US * `NS_PER_US / `CLK_PERIOD_NS,
  parameter [CNT_W-1:0] QCHG_CYC1 =
    `QCHG_T1_US * `NS_PER_US / `CLK_PERIOD_NS,
  parameter [CNT_W-1:0] QCHG_CYC2 =
    `QCHG_T2_US * `NS_PER_US / `CLK_PERIOD_NS,
  parameter [CNT_W-1:0] QCHG_CYC3 =
    `QCHG_T3_US * `NS_PER_US / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input  wire       CLK_SYS,
  input  wire       RESET,
  // Register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Supply monitors
  input  wire       ANALOG_SUPPLY_HIGH,
  input  wire       IO_SUPPLY_HIGH,
  input  wire       BROWNOUT_SHUTDOWN,
  // Power control
  output wire [7:0] PAGE,
  output reg        SLEEP,
  output reg        DIGITAL_REG_EN,
  output reg        REFERENCE_EN,
  output reg        QUICK_CHARGE,
  output reg        ANALOG_SUPPLY_BYPASS,
  output reg        IO_LOW_VOLTAGE_MODE,
  // Interrupt
  output wire       IRQ
);
  // ----------------------------------------------------------------
  // Tables and decode
  // ----------------------------------------------------------------
  localparam [8*`GEN_N-1:0] GEN_ADDR_TBL = `GEN_ADDRS;
  localparam [8*`GEN_N-1:0] GEN_RST_TBL  = `GEN_RESETS;
  localparam [`GEN_N-1:0]   GEN_RO       = `GEN_RO_MASK;
  reg  [7:0]          page_q;
  reg                 soft_rst_q;
  reg  [7:0]          refcfg_q;
  reg                 bo_wake_q;
  reg                 bo_flag_q;
  reg                 bo_prev_q;
  reg                 af_prev_q;
  reg                 iof_prev_q;
  reg  [`IRQ_W-1:0]   irq_stat_q;
  reg  [`IRQ_W-1:0]   irq_en_q;
  reg  [CNT_W-1:0]    qc_cnt_q;
  reg  [CNT_W-1:0]    qc_len;
  reg  [7:0]          rd_d;
  reg  [`IRQ_W-1:0]   irq_ev;
  reg  [`IRQ_W-1:0]   irq_stat_d;
  wire [8*`GEN_N-1:0] gen_flat;
  wire                qc_done;
  wire                ref_d;
  wire                awake_d;
  wire                on_page0;
  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a == target);
    end
  endfunction
  // Every page holds the selector; the rest of this bank is page 0
  assign on_page0 = (page_q == `RST_BYTE);
  // ----------------------------------------------------------------
  // Page selector and soft reset
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      page_q <= `RST_BYTE;
    end
    else if (soft_rst_q)
    begin
      page_q <= `RST_BYTE;
    end
    else if (WR && hit(ADDR, `ADDR_PAGE))
    begin
      page_q <= WDATA;
    end
  end
  assign PAGE = page_q;
  // Writing 0 does nothing; the pulse lasts one cycle, then clears
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      soft_rst_q <= 1'b0;
    end
    else
    begin
      soft_rst_q <= WR && on_page0 && !soft_rst_q &&
                    hit(ADDR, `ADDR_SWRST) &&
                    WDATA[`SWRST_BIT];
    end
  end
  // ----------------------------------------------------------------
  // Reference and sleep configuration
  // ----------------------------------------------------------------
  // Reserved bits 7-6 are stored as written; host keeps them zero
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      refcfg_q <= `RST_BYTE;
    end
    else if (soft_rst_q)
    begin
      refcfg_q <= `RST_BYTE;
    end
    else
    begin
      if (WR && on_page0 && hit(ADDR, `ADDR_REFCFG))
      begin
        refcfg_q <= WDATA;
      end
      if (ANALOG_SUPPLY_HIGH)
      begin
        refcfg_q[`ASUP_BIT] <= 1'b0;
      end
      if (IO_SUPPLY_HIGH)
      begin
        refcfg_q[`IOSUP_BIT] <= 1'b0;
      end
      // Wake choice applied as the brownout shutdown ends
      if (bo_prev_q && !BROWNOUT_SHUTDOWN)
      begin
        refcfg_q[`SLEEPN_BIT] <= bo_wake_q;
      end
      else if (BROWNOUT_SHUTDOWN)
      begin
        refcfg_q[`SLEEPN_BIT] <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Supply status and brownout
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      bo_wake_q  <= 1'b0;
      bo_flag_q  <= 1'b0;
      bo_prev_q  <= 1'b0;
      af_prev_q  <= 1'b0;
      iof_prev_q <= 1'b0;
    end
    else if (soft_rst_q)
    begin
      bo_wake_q  <= 1'b0;
      bo_flag_q  <= 1'b0;
      bo_prev_q  <= BROWNOUT_SHUTDOWN;
      af_prev_q  <= ANALOG_SUPPLY_HIGH;
      iof_prev_q <= IO_SUPPLY_HIGH;
    end
    else
    begin
      // Only the wake select is writable in this register
      if (WR && on_page0 && hit(ADDR, `ADDR_SUPPLY))
      begin
        bo_wake_q <= WDATA[`BOWAKE_BIT];
      end
      if (BROWNOUT_SHUTDOWN && !bo_prev_q)
      begin
        bo_flag_q <= 1'b1;
      end
      bo_prev_q  <= BROWNOUT_SHUTDOWN;
      af_prev_q  <= ANALOG_SUPPLY_HIGH;
      iof_prev_q <= IO_SUPPLY_HIGH;
    end
  end
  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  assign awake_d = refcfg_q[`SLEEPN_BIT] &&
                   !BROWNOUT_SHUTDOWN;
  assign ref_d   = awake_d && refcfg_q[`EXIT_REF_BIT];
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      SLEEP                <= 1'b1;
      DIGITAL_REG_EN       <= 1'b0;
      REFERENCE_EN         <= 1'b0;
      ANALOG_SUPPLY_BYPASS <= 1'b0;
      IO_LOW_VOLTAGE_MODE  <= 1'b0;
    end
    else
    begin
      SLEEP          <= !awake_d;
      DIGITAL_REG_EN <= awake_d;
      REFERENCE_EN   <= ref_d;
      ANALOG_SUPPLY_BYPASS <= refcfg_q[`ASUP_BIT] &&
                              !ANALOG_SUPPLY_HIGH;
      IO_LOW_VOLTAGE_MODE  <= refcfg_q[`IOSUP_BIT] &&
                              !IO_SUPPLY_HIGH;
    end
  end
  // ----------------------------------------------------------------
  // Reference quick-charge timer
  // ----------------------------------------------------------------
  always @*
  begin
    case (refcfg_q[`QCHG_HI:`QCHG_LO])
      2'h0:    qc_len = QCHG_CYC0;
      2'h1:    qc_len = QCHG_CYC1;
      2'h2:    qc_len = QCHG_CYC2;
      2'h3:    qc_len = QCHG_CYC3;
      default: qc_len = QCHG_CYC0;
    endcase
  end

  assign qc_done = QUICK_CHARGE && REFERENCE_EN &&
                   (qc_cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  // Charge starts as the reference turns on; dropping it aborts
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      QUICK_CHARGE <= 1'b0;
      qc_cnt_q     <= `RST_CNT;
    end
    else if (soft_rst_q || !ref_d || qc_done)
    begin
      QUICK_CHARGE <= 1'b0;
      qc_cnt_q     <= `RST_CNT;
    end
    else if (!REFERENCE_EN)
    begin
      QUICK_CHARGE <= 1'b1;
      qc_cnt_q     <= qc_len;
    end
    else if (QUICK_CHARGE)
    begin
      qc_cnt_q <= qc_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
  // ----------------------------------------------------------------
  // Remaining page-0 registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `GEN_N; gi = gi + 1)
    begin : g_reg
      reg [7:0] val_q;
      always @(posedge CLK_SYS or posedge RESET)
      begin
        if (RESET)
        begin
          val_q <= GEN_RST_TBL[8*gi +: 8];
        end
        else if (soft_rst_q)
        begin
          val_q <= GEN_RST_TBL[8*gi +: 8];
        end
        else if (WR && on_page0 && !GEN_RO[gi] &&
                 hit(ADDR, GEN_ADDR_TBL[8*gi +: 8]))
        begin
          val_q <= WDATA;
        end
      end
      assign gen_flat[8*gi +: 8] = val_q;
    end
  endgenerate
  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  always @*
  begin
    irq_ev = {`IRQ_W{1'b0}};
    irq_ev[`IRQ_BROWNOUT]  = BROWNOUT_SHUTDOWN && !bo_prev_q;
    irq_ev[`IRQ_AFORCED]   = ANALOG_SUPPLY_HIGH && !af_prev_q;
    irq_ev[`IRQ_IOFORCED]  = IO_SUPPLY_HIGH && !iof_prev_q;
    irq_ev[`IRQ_QCHG_DONE] = qc_done;
    irq_stat_d = irq_stat_q;
    if (WR && on_page0 && hit(ADDR, `ADDR_IRQ_CLR))
    begin
      irq_stat_d = irq_stat_q & ~WDATA[`IRQ_W-1:0];
    end
    // A new event outranks a clear in the same cycle
    irq_stat_d = irq_stat_d | irq_ev;
  end
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      irq_stat_q <= `RST_IRQ;
      irq_en_q   <= `RST_IRQ;
    end
    else if (soft_rst_q)
    begin
      irq_stat_q <= `RST_IRQ;
      irq_en_q   <= `RST_IRQ;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (WR && on_page0 && hit(ADDR, `ADDR_IRQ_EN))
      begin
        irq_en_q <= WDATA[`IRQ_W-1:0];
      end
    end
  end
  assign IRQ = |(irq_stat_q & irq_en_q);
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  integer ri;
  always @*
  begin
    rd_d = `RST_BYTE;
    if (hit(ADDR, `ADDR_PAGE))
    begin
      rd_d = page_q;
    end
    else if (on_page0)
    begin
      if (hit(ADDR, `ADDR_REFCFG))
      begin
        rd_d = refcfg_q;
      end
      else if (hit(ADDR, `ADDR_SUPPLY))
      begin
        rd_d[`AFORCED_BIT]  = ANALOG_SUPPLY_HIGH;
        rd_d[`IOFORCED_BIT] = IO_SUPPLY_HIGH;
        rd_d[`BOFLAG_BIT]   = bo_flag_q;
        rd_d[`BOWAKE_BIT]   = bo_wake_q;
      end
      else if (hit(ADDR, `ADDR_IRQ_STAT))
      begin
        rd_d[`IRQ_W-1:0] = irq_stat_q;
      end
      else if (hit(ADDR, `ADDR_IRQ_EN))
      begin
        rd_d[`IRQ_W-1:0] = irq_en_q;
      end
      else
      begin
        // Soft reset and clear register read as zero
        for (ri = 0; ri < `GEN_N; ri = ri + 1)
        begin
          if (hit(ADDR, GEN_ADDR_TBL[8*ri +: 8]))
          begin
            rd_d = gen_flat[8*ri +: 8];
          end
        end
      end
    end
  end
  // Data stand only in the cycle after the strobe
  always @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      RDATA <= `RST_BYTE;
    end
    else
    begin
      RDATA <= RD ? rd_d : `RST_BYTE;
    end
  end

endmodule // codec_page0_regs

`default_nettype wire

// [logic/codec_page0_defs.vh]
// Constants for the page-0 control register bank
`ifndef CODEC_PAGE0_DEFS_VH
`define CODEC_PAGE0_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_PAGE      8'h00
`define ADDR_SWRST     8'h01
`define ADDR_REFCFG    8'h02
`define ADDR_SUPPLY    8'h03
`define ADDR_IRQ_STAT  8'h7b
`define ADDR_IRQ_EN    8'h7c
`define ADDR_IRQ_CLR   8'h7d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWRST_BIT      0
`define QCHG_HI        5
`define QCHG_LO        4
`define EXIT_REF_BIT   3
`define ASUP_BIT       2
`define IOSUP_BIT      1
`define SLEEPN_BIT     0
`define AFORCED_BIT    7
`define IOFORCED_BIT   6
`define BOFLAG_BIT     1
`define BOWAKE_BIT     0
`define IRQ_BROWNOUT   0
`define IRQ_AFORCED    1
`define IRQ_IOFORCED   2
`define IRQ_QCHG_DONE  3
`define IRQ_W          4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE       8'h00
`define RST_IRQ        4'h0
`define RST_CNT        20'h00000

// ----------------------------------------------------------------
// Remaining page-0 registers, last entry first
// ----------------------------------------------------------------
`define GEN_N          24
`define GEN_ADDRS {8'h7e, 8'h7a, 8'h79, 8'h78, 8'h77, 8'h76, \
  8'h73, 8'h72, 8'h71, 8'h70, 8'h6f, 8'h6e, 8'h6d, 8'h6c, \
  8'h6b, 8'h6a, 8'h69, 8'h68, 8'h67, 8'h66, 8'h65, 8'h64, \
  8'h62, 8'h61}
`define GEN_RESETS {8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'hcc, \
  8'h18, 8'h18, 8'h80, 8'hc9, 8'h80, 8'hc9, 8'h20, 8'h20, \
  8'h20, 8'h80, 8'hc9, 8'h80, 8'hc9, 8'h20, 8'h20, 8'h20, \
  8'h00, 8'h00}
`define GEN_RO_MASK    24'h600000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  100
`define NS_PER_US      1000
`define QCHG_T0_US     3500
`define QCHG_T1_US     10000
`define QCHG_T2_US     50000
`define QCHG_T3_US     100000
`define CNT_W          20

`endif

// [tb/codec_page0_chk.sv]
// Checker: port-level properties of the page-0 register bank
`default_nettype none
module codec_page0_chk
#(
  parameter int QCHG_CYC3 = 10
)
(
  input wire logic       CLK_SYS,
  input wire logic       RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       ANALOG_SUPPLY_HIGH,
  input wire logic       IO_SUPPLY_HIGH,
  input wire logic       BROWNOUT_SHUTDOWN,
  input wire logic [7:0] PAGE,
  input wire logic       SLEEP,
  input wire logic       DIGITAL_REG_EN,
  input wire logic       REFERENCE_EN,
  input wire logic       QUICK_CHARGE,
  input wire logic       ANALOG_SUPPLY_BYPASS,
  input wire logic       IO_LOW_VOLTAGE_MODE,
  input wire logic       IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Length of the running quick-charge pulse
  logic [31:0] qcnt_q;
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
      qcnt_q <= 32'h0;
    else if (QUICK_CHARGE)
      qcnt_q <= qcnt_q + 32'h1;
    else
      qcnt_q <= 32'h0;
  a_rdata_quiet: assert property (RDATA != 8'h00 |-> $past(RD))
    else $error("read data outside the read answer cycle");
  a_page_store: assert property (WR && ADDR == 8'h00 |=>
    PAGE == $past(WDATA)) else $error("page select not stored");
  a_soft_sleep: assert property (WR && ADDR == 8'h01 && WDATA[0]
    && PAGE == 8'h00 |-> ##[1:4] SLEEP) else $error("soft reset no sleep");
  a_ref_digital_regulator: assert property (REFERENCE_EN |-> DIGITAL_REG_EN)
    else $error("reference on without digital regulator");
  a_qchg_ref: assert property (QUICK_CHARGE |-> REFERENCE_EN)
    else $error("quick charge without reference");
  a_qchg_min: assert property ($rose(QUICK_CHARGE) |->
    QUICK_CHARGE[*3]) else $error("quick charge too short");
  a_qchg_bound: assert property (qcnt_q <= QCHG_CYC3)
    else $error("quick charge too long");
  a_asup_force: assert property (ANALOG_SUPPLY_HIGH[*3] |->
    !ANALOG_SUPPLY_BYPASS) else $error("analog select not forced");
  a_iosup_force: assert property (IO_SUPPLY_HIGH[*3] |->
    !IO_LOW_VOLTAGE_MODE) else $error("io select not forced");
  a_brown_sleep: assert property (BROWNOUT_SHUTDOWN[*3] |-> SLEEP)
    else $error("awake during brownout");
  c_qchg: cover property ($rose(QUICK_CHARGE));
  c_irq: cover property ($rose(IRQ));
  c_read: cover property (RD ##1 RDATA != 8'h00);
endmodule // codec_page0_chk

bind codec_page0_regs codec_page0_chk #(.QCHG_CYC3(QCHG_CYC3))
  codec_page0_chk_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .ANALOG_SUPPLY_HIGH(ANALOG_SUPPLY_HIGH), .IO_SUPPLY_HIGH(IO_SUPPLY_HIGH),
  .BROWNOUT_SHUTDOWN(BROWNOUT_SHUTDOWN), .PAGE(PAGE), .SLEEP(SLEEP),
  .DIGITAL_REG_EN(DIGITAL_REG_EN), .REFERENCE_EN(REFERENCE_EN),
  .QUICK_CHARGE(QUICK_CHARGE), .ANALOG_SUPPLY_BYPASS(ANALOG_SUPPLY_BYPASS),
  .IO_LOW_VOLTAGE_MODE(IO_LOW_VOLTAGE_MODE), .IRQ(IRQ));
`default_nettype wire

// [tb/ctrl_host.sv]
// Host controller model driving the register port
`default_nettype none
module ctrl_host
(
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr,
  output var  logic       rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    // Reserved reference bits always go out as zero
    wdata <= (a == 8'h02) ? (d & 8'h3f) : d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule // ctrl_host
`default_nettype wire

// [tb/codec_page0_regs_tb_top.sv]
// Testbench for the page-0 register bank
`include "codec_page0_defs.vh"
`default_nettype none
module codec_page0_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QC[4] = '{4, 6, 8, 10};
  localparam logic [8*`GEN_N-1:0] GA = `GEN_ADDRS;
  localparam logic [8*`GEN_N-1:0] GR = `GEN_RESETS;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] addr, wdata, rdata, page;
  logic       wr, rd, sleep, digital_regulator, refen, qchg, bypass, iolv, irq;
  logic       ana_high = 1'b0;
  logic       io_high = 1'b0;
  logic       brown = 1'b0;
  int         fail_count = 0;
  int         n_compared = 0;
  int         i, n, k;
  always #50 clk_sys = ~clk_sys;
  ctrl_host ctrl_host_i (.clk(clk_sys), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  codec_page0_regs #(.QCHG_CYC0(20'd4), .QCHG_CYC1(20'd6),
    .QCHG_CYC2(20'd8), .QCHG_CYC3(20'd10)) codec_page0_regs_i (
    .CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .ANALOG_SUPPLY_HIGH(ana_high),
    .IO_SUPPLY_HIGH(io_high), .BROWNOUT_SHUTDOWN(brown), .PAGE(page),
    .SLEEP(sleep), .DIGITAL_REG_EN(digital_regulator), .REFERENCE_EN(refen),
    .QUICK_CHARGE(qchg), .ANALOG_SUPPLY_BYPASS(bypass),
    .IO_LOW_VOLTAGE_MODE(iolv), .IRQ(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    ctrl_host_i.read(a, d);
    chk(d, exp);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    ctrl_host_i.write(a, d);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Run is a few hundred cycles; the limit leaves wide margin
  initial
  begin
    #2000000;
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (i = 0; i < `GEN_N; i++)
      rc(GA[8*i +: 8], GR[8*i +: 8]);
    for (i = 0; i < 4; i++)
      rc(i[7:0], 8'h00);
    wr8(8'h79, 8'h5a);
    rc(8'h79, 8'h00);
    wr8(8'h7a, 8'h00);
    rc(8'h7a, 8'h80);
    wr8(8'h50, 8'hff);
    rc(8'h50, 8'h00);
    wr8(8'h76, 8'h33);
    wr8(8'h00, 8'hff);
    rc(8'h00, 8'hff);
    chk(page, 8'hff);
    rc(8'h76, 8'h00);
    wr8(8'h00, 8'h00);
    rc(8'h76, 8'h33);
    chk(page, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr8(8'h02, 8'h00);
      wr8(8'h02, {2'b00, i[1:0], 4'h9});
      k = 0;
      while (!qchg && k < 20)
      begin
        cyc(1);
        k++;
      end
      chk({5'h0, sleep, digital_regulator, refen}, 8'h03);
      n = 0;
      while (qchg && n < 50)
      begin
        n++;
        cyc(1);
      end
      chk(n[7:0], QC[i][7:0]);
    end
    wr8(8'h02, 8'h01);
    cyc(2);
    chk({5'h0, sleep, digital_regulator, refen}, 8'h02);
    wr8(8'h02, 8'h07);
    cyc(2);
    chk({6'h0, bypass, iolv}, 8'h03);
    @(posedge clk_sys);
    ana_high <= 1'b1;
    io_high  <= 1'b1;
    cyc(4);
    chk({6'h0, bypass, iolv}, 8'h00);
    rc(8'h03, 8'hc0);
    rc(8'h02, 8'h01);
    @(posedge clk_sys);
    ana_high <= 1'b0;
    io_high  <= 1'b0;
    cyc(2);
    rc(8'h03, 8'h00);
    wr8(8'h7d, 8'h0f);
    wr8(8'h7c, 8'h01);
    wr8(8'h03, 8'h01);
    @(posedge clk_sys);
    brown <= 1'b1;
    cyc(4);
    chk({6'h0, sleep, irq}, 8'h03);
    @(posedge clk_sys);
    brown <= 1'b0;
    cyc(3);
    chk({7'h0, sleep}, 8'h00);
    wr8(8'h03, 8'h00);
    rc(8'h03, 8'h02);
    rc(8'h7b, 8'h01);
    wr8(8'h7c, 8'h00);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    wr8(8'h7c, 8'h01);
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    wr8(8'h7d, 8'h01);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    rc(8'h7d, 8'h00);
    // Second brownout with the wake select cleared: stays asleep
    @(posedge clk_sys);
    brown <= 1'b1;
    cyc(2);
    @(posedge clk_sys);
    brown <= 1'b0;
    cyc(3);
    chk({7'h0, sleep}, 8'h01);
    rc(8'h02, 8'h00);
    wr8(8'h01, 8'h01);
    cyc(3);
    rc(8'h02, 8'h00);
    rc(8'h03, 8'h00);
    rc(8'h76, 8'hcc);
    rc(8'h7c, 8'h00);
    rc(8'h01, 8'h00);
    chk({7'h0, sleep}, 8'h01);
    end_of_test();
  end
endmodule // codec_page0_regs_tb_top
`default_nettype wire
